/* hw/udcb_pkg.sv */
/*
  Shared constants and carrier types for the one-bit cascadable
  up/down counter stage.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package udcb_pkg;

  // value the stored bit takes on clear or reset
  localparam logic UDCB_CLEAR_VAL = 1'h0;
  // direction encoding: high counts down, low counts up
  localparam logic UDCB_DIR_UP = 1'h0;
  localparam logic UDCB_DIR_DOWN = 1'h1;

  // per-edge control inputs of one stage
  typedef struct packed {
    logic parallel_load_n;
    logic count_en;
    logic carry_in;
    logic count_down;
    logic data;
  } udcb_ctrl_t;

endpackage

/* hw/udcb_stage.sv */
/*
  One bit of a cascadable up/down counter with parallel load,
  asynchronous clear and a ripple carry toward the next stage.
  Assumes the surrounding logic supplies clk and its complement clk_n
  together, and chains carry_out of one stage into carry_in of the next.
  clear_n may fall or rise at any time; rst is sampled only on the
  falling edge of clk, like every other control input.
*/
// Functional notes
// - one counter bit, chainable into wider counters
// - counts only with enable high, else holds unless loaded
// - load and count on falling true clock
// - low clear zeroes bit at once, overrides
// - ripple carry out toward next stage
// - steps only when incoming carry is high
`timescale 1ns/1ps

module udcb_stage
  import udcb_pkg::*;
(
  input wire logic clk,
  input wire logic clk_n,
  input wire logic rst,
  input wire logic clear_n,
  input wire udcb_ctrl_t ctrl,
  output logic q,
  output logic q_n,
  output logic carry_out
);

  logic q_reg;
  logic q_next;
  logic qn_reg;
  logic q_mid_reg;

  ////////////////////////////////////////////////////////////////////////
  // next value of the stored bit
  // load wins over count; a count needs both enable and incoming carry
  function automatic logic udcb_next_bit(input udcb_ctrl_t c,
                                         input logic cur);
    logic nb;
    nb = cur;
    if (!c.parallel_load_n) begin
      nb = c.data;
    end else if (c.count_en && c.carry_in) begin
      nb = ~cur;
    end
    return nb;
  endfunction

  // decide the value taken at the coming falling edge
  always_comb begin
    q_next = udcb_next_bit(ctrl, q_reg);
  end

  ////////////////////////////////////////////////////////////////////////
  // state bit: falling edge of the true clock, async low clear
  // rst is sampled on the same edge; clear_n wins over rst and all else
  always_ff @(negedge clk or negedge clear_n) begin
    if (!clear_n) begin
      q_reg <= UDCB_CLEAR_VAL;
    end else if (rst) begin
      q_reg <= UDCB_CLEAR_VAL;
    end else begin
      q_reg <= q_next;
    end
  end

  // complement kept in its own flop so both outputs are registered
  always_ff @(negedge clk or negedge clear_n) begin
    if (!clear_n) begin
      qn_reg <= ~UDCB_CLEAR_VAL;
    end else if (rst) begin
      qn_reg <= ~UDCB_CLEAR_VAL;
    end else begin
      qn_reg <= ~q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit as seen at mid-cycle on the falling edge of the complement clock;
  // it only tracks q_reg if clk_n really falls between true falling edges
  always_ff @(negedge clk_n or negedge clear_n) begin
    if (!clear_n) begin
      q_mid_reg <= UDCB_CLEAR_VAL;
    end else begin
      q_mid_reg <= q_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; carry ripples without a flop so a chain settles in one cycle
  // the carry cannot be registered: the next stage must see it in the
  // same cycle, so a long chain limits the clock rate
  assign q = q_reg;
  assign q_n = qn_reg;
  assign carry_out = ctrl.carry_in &
    ((ctrl.count_down == UDCB_DIR_DOWN) ? ~q_reg : q_reg);

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_load_capture: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    !ctrl.parallel_load_n |=> q == $past(ctrl.data))
    else $error("load did not capture data bit");

  chk_hold_disabled: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.parallel_load_n && !ctrl.count_en |=> $stable(q))
    else $error("bit changed while count disabled");

  chk_count_toggle: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.parallel_load_n && ctrl.count_en && ctrl.carry_in
    |=> q != $past(q))
    else $error("enabled count with carry did not toggle");

  chk_carry_gate: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.parallel_load_n && !ctrl.carry_in |=> $stable(q))
    else $error("bit stepped without incoming carry");

  chk_clear_force: assert property (
    @(posedge clk) !clear_n |-> (q == UDCB_CLEAR_VAL && q_n != q))
    else $error("clear did not zero the bit");

  chk_carry_next: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.parallel_load_n && ctrl.count_en && ctrl.carry_in
    && ctrl.count_down == UDCB_DIR_UP && q
    |=> !q && $past(carry_out))
    else $error("up count from one lacked carry out");

  chk_clock_pair: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    q == q_mid_reg)
    else $error("bit changed away from the true falling edge");

  chk_q_pair: assert property (
    @(negedge clk) disable iff (rst || !clear_n) ##1 q_n == ~q)
    else $error("q and q_n not complementary");

  chk_qn_load: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    !ctrl.parallel_load_n |=> q_n != $past(ctrl.data))
    else $error("load did not set the complement output");

  chk_qn_hold: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.parallel_load_n && !ctrl.count_en |=> $stable(q_n))
    else $error("complement changed while count disabled");

  chk_qn_toggle: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.parallel_load_n && ctrl.count_en && ctrl.carry_in
    |=> q_n != $past(q_n))
    else $error("complement did not toggle on enabled count");

  chk_load_priority: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    !ctrl.parallel_load_n && ctrl.count_en && ctrl.carry_in
    |=> q == $past(ctrl.data))
    else $error("count overrode a parallel load");

  chk_step_up_zero: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.parallel_load_n && ctrl.count_en && ctrl.carry_in
    && ctrl.count_down == UDCB_DIR_UP && !q
    |=> q && !$past(carry_out))
    else $error("up count from zero went wrong");

  chk_step_down_zero: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.parallel_load_n && ctrl.count_en && ctrl.carry_in
    && ctrl.count_down == UDCB_DIR_DOWN && !q
    |=> q && $past(carry_out))
    else $error("down count from zero lacked carry out");

  chk_step_down_one: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.parallel_load_n && ctrl.count_en && ctrl.carry_in
    && ctrl.count_down == UDCB_DIR_DOWN && q
    |=> !q && !$past(carry_out))
    else $error("down count from one went wrong");

  ////////////////////////////////////////////////////////////////////////
  // checks on the ripple carry, sampled where inputs and bit are settled
  chk_carry_blocked: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    !ctrl.carry_in |-> !carry_out)
    else $error("carry out without incoming carry");

  chk_carry_up_one: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.carry_in && ctrl.count_down == UDCB_DIR_UP && q |-> carry_out)
    else $error("up carry missing at bit one");

  chk_carry_up_zero: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.carry_in && ctrl.count_down == UDCB_DIR_UP && !q |-> !carry_out)
    else $error("up carry raised at bit zero");

  chk_carry_down_zero: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.carry_in && ctrl.count_down == UDCB_DIR_DOWN && !q |-> carry_out)
    else $error("down carry missing at bit zero");

  chk_carry_down_one: assert property (
    @(negedge clk) disable iff (rst || !clear_n)
    ctrl.carry_in && ctrl.count_down == UDCB_DIR_DOWN && q |-> !carry_out)
    else $error("down carry raised at bit one");

  ////////////////////////////////////////////////////////////////////////
  // checks on clear and reset
  chk_clear_hold: assert property (
    @(negedge clk)
    !clear_n |-> q == UDCB_CLEAR_VAL && q_n != UDCB_CLEAR_VAL)
    else $error("bit not held at zero through clear");

  chk_reset_zero: assert property (
    @(negedge clk) disable iff (!clear_n)
    rst |=> q == UDCB_CLEAR_VAL && q_n != UDCB_CLEAR_VAL)
    else $error("synchronous reset did not zero the bit");

endmodule

/* test/udcb_clk_pair.sv */
/* clock pair source for the counter stage
   assumes a free running true clock */
`timescale 1ns/1ps
module udcb_clk_pair (
  input wire logic clk,
  output logic clk_n
);
  // both phases supplied together
  assign clk_n = ~clk;
endmodule

/* test/udcb_stage_tb_top.sv */
/* self-checking bench for one counter stage
   assumes the stage and the clock pair model */
`timescale 1ns/1ps
module udcb_stage_tb_top
  import udcb_pkg::*;
;
  logic clk = 0, rst = 1, clear_n = 1, clk_n, q, q_n, carry_out;
  udcb_ctrl_t c = '0;
  int bad_count = 0, compares = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  udcb_clk_pair PM (.clk(clk), .clk_n(clk_n));
  udcb_stage DUT (.clk(clk), .clk_n(clk_n), .rst(rst), .clear_n(clear_n),
    .ctrl(c), .q(q), .q_n(q_n), .carry_out(carry_out));
  task chk(input logic ok, input string m);
    compares++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // drive after rise, carry before fall, bit after fall
  task step(input udcb_ctrl_t v, input logic eq, input logic ec);
    @(posedge clk);
    #1 c = v;
    #1 chk(carry_out === ec, "carry");
    @(negedge clk);
    #1 chk(q === eq && q_n === !eq, "bit");
  endtask
  task t_load;
    step(5'h00, 1'h0, 1'h0);
    step(5'h0D, 1'h1, 1'h0);
  endtask
  task t_count;
    step(5'h1C, 1'h0, 1'h1);
    step(5'h1E, 1'h1, 1'h1);
    step(5'h16, 1'h1, 1'h0);
    step(5'h18, 1'h1, 1'h0);
    step(5'h1E, 1'h0, 1'h0);
    step(5'h1C, 1'h1, 1'h0);
  endtask
  task t_clear;
    @(posedge clk);
    #1 c = 5'h01;
    clear_n = 0;
    #1 chk(q === 1'h0 && q_n === 1'h1, "clear");
    @(posedge clk);
    #1 chk(q === 1'h0 && q_n === 1'h1, "override");
    clear_n = 1;
    step(5'h01, 1'h1, 1'h0);
    @(posedge clk);
    #1 rst = 1;
    @(negedge clk);
    #1 chk(q === 1'h0 && q_n === 1'h1, "reset");
    @(posedge clk);
    #1 rst = 0;
    step(5'h01, 1'h1, 1'h0);
  endtask
  task tally_and_finish;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    t_load();
    t_count();
    t_clear();
    tally_and_finish();
  end
  // watchdog, run needs about 341 ns, well under the 5000 ns limit
  initial begin
    #5000;
    bad_count++;
    tally_and_finish();
  end
endmodule
